// *** ccfg_defines.svh ***
// Register indices, field positions, reset values and timing counts of the clock path configuration block.
// Assumes a 32-bit AHB-Lite register bus with one word per register index.
`ifndef CCFG_DEFINES_SVH
`define CCFG_DEFINES_SVH

// Register indices, byte address is index times four
`define CCFG_IDX_PLL_CTRL 10'h010
`define CCFG_IDX_CAL_CTRL 10'h018
`define CCFG_IDX_PRESCALE 10'h1e0
`define CCFG_IDX_ROUTING 10'h1e1
`define CCFG_IDX_UPDATE 10'h232
`define CCFG_IDX_STATUS 10'h233

// Field positions
`define CCFG_PLL_PWR_LSB 0
`define CCFG_PLL_PWR_MSB 1
`define CCFG_PFD_POL_BIT 7
`define CCFG_CAL_BIT 0
`define CCFG_DIV_LSB 0
`define CCFG_DIV_MSB 2
`define CCFG_BYPASS_BIT 0
`define CCFG_SRC_BIT 1
`define CCFG_UPDATE_BIT 0

// Field encodings
`define CCFG_PLL_PWR_NORMAL 2'h0
`define CCFG_PLL_PWR_DOWN 2'h1

// Reset values
`define CCFG_RST_PLL_CTRL 8'h01
`define CCFG_RST_CAL_CTRL 8'h00
`define CCFG_RST_PRESCALE 8'h02
`define CCFG_RST_ROUTING 8'h00

// Calibration run time
`define CCFG_CAL_TIME_NS 2000
`define CCFG_CLK_PERIOD_NS 5
`define CCFG_CAL_CYCLES (`CCFG_CAL_TIME_NS / `CCFG_CLK_PERIOD_NS)

`endif

// *** ccfg_pkg.sv ***
// Types of the clock path configuration block.
// Assumes ccfg_defines.svh holds all numeric constants.
package ccfg_pkg;

  typedef enum logic [0:0] {
    CCFG_CAL_IDLE = 1'b0,
    CCFG_CAL_RUN = 1'b1
  } ccfg_cal_state_t;

  typedef logic [7:0] ccfg_byte_t;

endpackage

// *** ccfg_div_if.sv ***
// Carrier between the configuration core and the prescaling divider.
// Assumes both ends run on the one system clock.
`timescale 1ns/1ps
interface ccfg_div_if;
  logic [2:0] ratio_code;
  logic bypass;
  logic tick;

  modport core (output ratio_code, output bypass, input tick);
  modport div (input ratio_code, input bypass, output tick);
endinterface

// *** ccfg_prescaler.sv ***
// Prescaling divider modelled as a one-cycle enable pulse on the system clock.
// Assumes ratio and bypass change only on an update strobe.
`timescale 1ns/1ps
module ccfg_prescaler (
  input wire logic clk,
  input wire logic rst_n,
  ccfg_div_if.div dv
);
  logic [2:0] cnt_q;
  logic [2:0] last_d;

  ////////////////////////////////////////////////////////////////////////
  // Ratio decode, codes above divide-by-6 saturate there
  // minimum ratio two
  always_comb begin
    case (dv.ratio_code)
      3'h0: last_d = 3'h1;
      3'h1: last_d = 3'h2;
      3'h2: last_d = 3'h3;
      3'h3: last_d = 3'h4;
      default: last_d = 3'h5;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // divided output feeds distribution
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
    end else if (dv.bypass || cnt_q >= last_d) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dv.tick <= 1'b0;
    end else begin
      dv.tick <= dv.bypass || (cnt_q >= last_d);
    end
  end
endmodule

// *** ccfg_clock_path.sv ***
// Clock source and routing configuration with staged registers and oscillator calibration.
// Assumes an AHB-Lite master issuing single word transfers; hready is this slave's HREADYOUT.
`timescale 1ns/1ps
`include "ccfg_defines.svh"
module ccfg_clock_path
  import ccfg_pkg::*;
#(
  parameter int CAL_CYCLES = `CCFG_CAL_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic HSEL,
  input wire logic [11:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic PLL_POWER_DOWN,
  output logic PFD_POLARITY_NEG,
  output logic OSC_POWER_ON,
  output logic EXT_TO_PRESCALER,
  output logic SRC_IS_OSC,
  output logic DIV_BYPASS,
  output logic [2:0] DIV_RATIO_CODE,
  output logic DIST_CLK_EN,
  output logic CAL_START,
  output logic CAL_BUSY
);
  ccfg_byte_t pll_stage_q, cal_stage_q, div_stage_q, route_stage_q;
  ccfg_byte_t pll_act_q, cal_act_q, div_act_q, route_act_q;
  logic wr_pend_q;
  logic [9:0] wr_idx_q;
  logic update_now;
  logic cal_prev_q;
  logic [31:0] cal_cnt_q;
  ccfg_cal_state_t cal_state_q;
  logic [31:0] rd_d;
  logic [9:0] a_idx;
  logic a_valid;
  ccfg_div_if dvif();

  ////////////////////////////////////////////////////////////////////////
  // Bus address phase, zero wait states
  assign a_idx = HADDR[11:2];
  assign a_valid = HSEL && HTRANS[1] && HREADY;

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 10'h000;
    end else begin
      wr_pend_q <= a_valid && HWRITE;
      if (a_valid) begin
        wr_idx_q <= a_idx;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // Control register reads return staged values so software sees what it wrote; status reads return active values
  always_comb begin
    rd_d = 32'h0000_0000;
    case (a_idx)
      `CCFG_IDX_PLL_CTRL: rd_d[7:0] = pll_stage_q;
      `CCFG_IDX_CAL_CTRL: rd_d[7:0] = cal_stage_q;
      `CCFG_IDX_PRESCALE: rd_d[7:0] = div_stage_q;
      `CCFG_IDX_ROUTING: rd_d[7:0] = route_stage_q;
      `CCFG_IDX_STATUS: rd_d[3:0] = {cal_state_q == CCFG_CAL_RUN, route_act_q[1:0], pll_act_q[0]};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Read data is captured at the address phase to stand in the data phase
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      HRDATA <= 32'h0000_0000;
    end else if (a_valid && !HWRITE) begin
      HRDATA <= rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Staging registers, one per word so a write touches only its own register
  // distribution-only defaults
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pll_stage_q <= `CCFG_RST_PLL_CTRL;
    end else if (wr_pend_q && (wr_idx_q == `CCFG_IDX_PLL_CTRL)) begin
      pll_stage_q <= HWDATA[7:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cal_stage_q <= `CCFG_RST_CAL_CTRL;
    end else if (wr_pend_q && (wr_idx_q == `CCFG_IDX_CAL_CTRL)) begin
      cal_stage_q <= HWDATA[7:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_stage_q <= `CCFG_RST_PRESCALE;
    end else if (wr_pend_q && (wr_idx_q == `CCFG_IDX_PRESCALE)) begin
      div_stage_q <= HWDATA[7:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      route_stage_q <= `CCFG_RST_ROUTING;
    end else if (wr_pend_q && (wr_idx_q == `CCFG_IDX_ROUTING)) begin
      route_stage_q <= HWDATA[7:0];
    end
  end

  assign update_now = wr_pend_q && (wr_idx_q == `CCFG_IDX_UPDATE) && HWDATA[`CCFG_UPDATE_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Active registers, all four load on the same update edge
  // reset restores defaults
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pll_act_q <= `CCFG_RST_PLL_CTRL;
    end else if (update_now) begin
      pll_act_q <= pll_stage_q;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cal_act_q <= `CCFG_RST_CAL_CTRL;
    end else if (update_now) begin
      cal_act_q <= cal_stage_q;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_act_q <= `CCFG_RST_PRESCALE;
    end else if (update_now) begin
      div_act_q <= div_stage_q;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      route_act_q <= `CCFG_RST_ROUTING;
    end else if (update_now) begin
      route_act_q <= route_stage_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Routing outputs
  // power field decode, unused codes also power down
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PLL_POWER_DOWN <= 1'b1;
    end else begin
      PLL_POWER_DOWN <= pll_act_q[`CCFG_PLL_PWR_MSB:`CCFG_PLL_PWR_LSB] != `CCFG_PLL_PWR_NORMAL;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PFD_POLARITY_NEG <= 1'b0;
    end else begin
      PFD_POLARITY_NEG <= pll_act_q[`CCFG_PFD_POL_BIT];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      OSC_POWER_ON <= 1'b0;
    end else begin
      OSC_POWER_ON <= route_act_q[`CCFG_SRC_BIT];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      EXT_TO_PRESCALER <= 1'b0;
    end else begin
      EXT_TO_PRESCALER <= (pll_act_q[`CCFG_PLL_PWR_MSB:`CCFG_PLL_PWR_LSB] == `CCFG_PLL_PWR_NORMAL)
                          && !route_act_q[`CCFG_SRC_BIT];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SRC_IS_OSC <= 1'b0;
    end else begin
      SRC_IS_OSC <= route_act_q[`CCFG_SRC_BIT];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DIV_BYPASS <= 1'b0;
    end else begin
      DIV_BYPASS <= route_act_q[`CCFG_BYPASS_BIT];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DIV_RATIO_CODE <= 3'(`CCFG_RST_PRESCALE);
    end else begin
      DIV_RATIO_CODE <= div_act_q[`CCFG_DIV_MSB:`CCFG_DIV_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Prescaler
  // prescaler in the path unless bypassed
  assign dvif.ratio_code = div_act_q[`CCFG_DIV_MSB:`CCFG_DIV_LSB];
  assign dvif.bypass = route_act_q[`CCFG_BYPASS_BIT];

  ccfg_prescaler u_prescaler (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .dv(dvif.div)
  );

  // Retimed so the output comes straight from a flop, one cycle later than the tick
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DIST_CLK_EN <= 1'b0;
    end else begin
      DIST_CLK_EN <= dvif.tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Calibration
  // start on active bit rising, first run needs no clear
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cal_prev_q <= 1'b0;
    end else begin
      cal_prev_q <= cal_act_q[`CCFG_CAL_BIT];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cal_state_q <= CCFG_CAL_IDLE;
      cal_cnt_q <= 32'h0000_0000;
      CAL_START <= 1'b0;
      CAL_BUSY <= 1'b0;
    end else begin
      CAL_START <= 1'b0;
      case (cal_state_q)
        CCFG_CAL_IDLE: begin
          if (cal_act_q[`CCFG_CAL_BIT] && !cal_prev_q) begin
            cal_state_q <= CCFG_CAL_RUN;
            cal_cnt_q <= 32'h0000_0000;
            CAL_START <= 1'b1;
            CAL_BUSY <= 1'b1;
          end
        end
        CCFG_CAL_RUN: begin
          // A run in progress finishes even if the bit is cleared meanwhile
          if (cal_cnt_q >= 32'(CAL_CYCLES - 1)) begin
            cal_state_q <= CCFG_CAL_IDLE;
            CAL_BUSY <= 1'b0;
          end else begin
            cal_cnt_q <= cal_cnt_q + 32'h0000_0001;
          end
        end
        default: begin
          cal_state_q <= CCFG_CAL_IDLE;
          CAL_BUSY <= 1'b0;
        end
      endcase
    end
  end
endmodule

// *** ccfg_clock_path_assertions.sv ***
// Port checker for the clock path configuration block.
// Assumes one clock domain and HREADY tied to the slave's HREADYOUT.
`timescale 1ns/1ps
`include "ccfg_defines.svh"
module ccfg_clock_path_chk #(
  parameter int CAL_CYCLES = 4
) (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic HSEL,
  input wire logic [11:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic PLL_POWER_DOWN,
  input wire logic PFD_POLARITY_NEG,
  input wire logic OSC_POWER_ON,
  input wire logic EXT_TO_PRESCALER,
  input wire logic SRC_IS_OSC,
  input wire logic DIV_BYPASS,
  input wire logic [2:0] DIV_RATIO_CODE,
  input wire logic DIST_CLK_EN,
  input wire logic CAL_START,
  input wire logic CAL_BUSY
);
////////////////////////////////////////////////////////////////////////////////
  logic upd_a_q;
  logic [3:0] upd_q;
  logic [31:0] busy_len_q;
  // History of update strobes; active outputs may only move inside it
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      upd_a_q <= 1'b0;
      upd_q <= 4'h0;
    end else begin
      upd_a_q <= HSEL && HTRANS[1] && HREADY && HWRITE && (HADDR[11:2] == `CCFG_IDX_UPDATE);
      upd_q <= {upd_q[2:0], upd_a_q && HWDATA[0]};
    end
  end
  // Length of the running calibration, judged against the parameter when it ends
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      busy_len_q <= 32'h0000_0000;
    end else if (CAL_BUSY) begin
      busy_len_q <= busy_len_q + 32'h0000_0001;
    end else begin
      busy_len_q <= 32'h0000_0000;
    end
  end
////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  stage_hold_a:
    assert property ($changed({PLL_POWER_DOWN, PFD_POLARITY_NEG, SRC_IS_OSC, DIV_BYPASS, DIV_RATIO_CODE}) |-> |upd_q)
    else $error("active setting moved without update");
  osc_power_a:
    assert property (OSC_POWER_ON == SRC_IS_OSC) else $error("oscillator power differs from source");
  ext_feed_a:
    assert property (EXT_TO_PRESCALER == (!PLL_POWER_DOWN && !SRC_IS_OSC)) else $error("external feed wrong");
  bypass_run_a:
    assert property (DIV_BYPASS [*3] |-> DIST_CLK_EN) else $error("bypass not every cycle");
  min_div_a:
    assert property ((!DIV_BYPASS) [*3] ##0 DIST_CLK_EN |=> !DIST_CLK_EN) else $error("divide below two");
  div_four_a:
    assert property ((DIST_CLK_EN && !DIV_BYPASS && DIV_RATIO_CODE == 3'h2) ##1
      (!DIST_CLK_EN && !DIV_BYPASS && DIV_RATIO_CODE == 3'h2) [*3] |=> DIST_CLK_EN)
    else $error("divide by four period wrong");
  cal_cause_a:
    assert property (CAL_START |-> (|upd_q) ##[0:1] CAL_BUSY) else $error("calibration start without update");
  cal_pulse_a:
    assert property (CAL_START |=> !CAL_START) else $error("calibration start too long");
  cal_length_a:
    assert property ($fell(CAL_BUSY) |-> busy_len_q == 32'(CAL_CYCLES)) else $error("calibration length wrong");
endmodule

bind ccfg_clock_path ccfg_clock_path_chk #(.CAL_CYCLES(CAL_CYCLES)) u_chk (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HWDATA(HWDATA), .HREADY(HREADY), .PLL_POWER_DOWN(PLL_POWER_DOWN), .PFD_POLARITY_NEG(PFD_POLARITY_NEG),
  .OSC_POWER_ON(OSC_POWER_ON), .EXT_TO_PRESCALER(EXT_TO_PRESCALER), .SRC_IS_OSC(SRC_IS_OSC),
  .DIV_BYPASS(DIV_BYPASS), .DIV_RATIO_CODE(DIV_RATIO_CODE), .DIST_CLK_EN(DIST_CLK_EN),
  .CAL_START(CAL_START), .CAL_BUSY(CAL_BUSY));

// *** testbench.sv ***
// Self-checking bench for the clock path configuration block.
// Assumes the port checker is bound in from its own file.
`timescale 1ns/1ps
`include "ccfg_defines.svh"
module testbench;
  localparam logic [9:0] I_PLL = `CCFG_IDX_PLL_CTRL;
  localparam logic [9:0] I_CAL = `CCFG_IDX_CAL_CTRL;
  localparam logic [9:0] I_PRE = `CCFG_IDX_PRESCALE;
  localparam logic [9:0] I_ROU = `CCFG_IDX_ROUTING;
  localparam logic [9:0] I_UPD = `CCFG_IDX_UPDATE;
  localparam int CAL_N = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [11:0] haddr = 12'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd_q;
  wire logic [31:0] hrdata;
  wire logic hready, hresp, pd, neg, osc, ext, src, byp, den, cst, cbsy;
  wire logic [2:0] rat;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
////////////////////////////////////////////////////////////////////////////////
  ccfg_clock_path #(.CAL_CYCLES(CAL_N)) u_dut (
    .SYS_CLK(clk), .RESET_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .PLL_POWER_DOWN(pd), .PFD_POLARITY_NEG(neg), .OSC_POWER_ON(osc), .EXT_TO_PRESCALER(ext),
    .SRC_IS_OSC(src), .DIV_BYPASS(byp), .DIV_RATIO_CODE(rat), .DIST_CLK_EN(den), .CAL_START(cst),
    .CAL_BUSY(cbsy));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Cut a hang short well past the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      mismatches++;
      results();
    end
  end
////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic [9:0] idx, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {idx, 2'h0};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd_q = hrdata;
  endtask
  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 32'h0);
    chk(rd_q, exp);
  endtask
  // Outputs reach their flops one cycle after the update data phase ends
  task automatic apply();
    bus(I_UPD, 1'b1, 32'h1);
    repeat (4) @(posedge clk);
  endtask
  // Sampled mid-cycle so flop updates have landed
  task automatic co(input logic [31:0] exp);
    @(negedge clk);
    chk({22'h0, hresp, pd, neg, osc, ext, src, byp, rat}, exp);
  endtask
  task automatic per(input int exp);
    int n;
    n = 0;
    @(negedge clk);
    while (den !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (den !== 1'b1 && n < 20);
    chk(32'(n), 32'(exp));
  endtask
////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    co(32'h102);
    rd(I_PLL, 32'h1);
    rd(I_CAL, 32'h0);
    rd(I_PRE, 32'h2);
    rd(I_ROU, 32'h0);
    per(4);
  endtask
  task automatic t_stage();
    bus(I_PLL, 1'b1, 32'h80);
    bus(I_ROU, 1'b1, 32'h2);
    bus(I_PRE, 1'b1, 32'h0);
    co(32'h102);
    rd(I_PLL, 32'h80);
    bus(I_UPD, 1'b1, 32'h0);
    repeat (4) @(posedge clk);
    co(32'h102);
    apply();
    co(32'h0d0);
    per(2);
    bus(I_ROU, 1'b1, 32'h0);
    apply();
    co(32'h0a0);
  endtask
  task automatic t_div();
    for (int c = 0; c < 8; c++) begin
      bus(I_PRE, 1'b1, 32'(c));
      apply();
      per(c > 4 ? 6 : c + 2);
    end
    bus(I_ROU, 1'b1, 32'h1);
    apply();
    per(1);
    bus(I_ROU, 1'b1, 32'h0);
    apply();
    per(6);
  endtask
  task automatic t_pwr();
    for (int i = 0; i < 4; i++) begin
      bus(I_PLL, 1'b1, 32'(i));
      apply();
      co(i == 0 ? 32'h027 : 32'h107);
    end
  endtask
  task automatic t_map();
    rd(10'h000, 32'h0);
    bus(10'h100, 1'b1, 32'hff);
    rd(10'h100, 32'h0);
    rd(I_UPD, 32'h0);
    rd(`CCFG_IDX_STATUS, 32'h1);
  endtask
  task automatic t_cal();
    int n;
    bus(I_CAL, 1'b1, 32'h0);
    apply();
    bus(I_CAL, 1'b1, 32'h1);
    bus(I_UPD, 1'b1, 32'h1);
    n = 0;
    while (cst !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, cst}, 32'h1);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cbsy === 1'b1 && n < 20);
    chk(32'(n), 32'(CAL_N));
  endtask
  task automatic t_rst();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    co(32'h102);
    rd(I_PLL, 32'h1);
    rd(I_PRE, 32'h2);
    rd(I_ROU, 32'h0);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_stage();
    t_div();
    t_pwr();
    t_map();
    t_cal();
    t_rst();
    results();
  end
endmodule
